// [verilog/cal_regs_pkg.sv]
`default_nettype none
package cal_regs_pkg;
	localparam int WORD_W = 16;
	localparam int DATA_W = 14;
	localparam int NUM_CAL = 10;
	localparam int NUM_DAC = 8;
	// pointer positions in walk order: gain, offset, dac0..dac7
	localparam logic [3:0] PTR_GAIN = 4'h0;
	localparam logic [3:0] PTR_OFFSET = 4'h1;
	localparam logic [3:0] PTR_LAST = 4'h9;
	// calibration select encodings
	localparam logic [1:0] SEL_ALL = 2'h0;
	localparam logic [1:0] SEL_GAIN_OFF = 2'h1;
	localparam logic [1:0] SEL_OFF = 2'h2;
	localparam logic [1:0] SEL_GAIN = 2'h3;
	// read select encodings
	localparam logic [1:0] RD_CAL = 2'h2;
	localparam logic [1:0] RD_STATUS = 2'h3;
	// status word field positions
	localparam int ST_BUSY = 14;
	localparam int ST_PM_HI = 9;
	localparam int ST_PM_LO = 8;
	localparam int ST_RD_HI = 7;
	localparam int ST_RD_LO = 6;
	localparam int ST_MODE = 5;
	localparam int ST_KIND = 3;
	localparam int ST_SEL_HI = 2;
	localparam int ST_SEL_LO = 1;
	localparam int ST_CAL = 0;
	// control word field positions
	localparam int CT_PM_LO = 8;
	localparam int CT_RD_LO = 6;
	localparam int CT_MODE = 5;
	localparam int CT_KIND = 3;
	localparam int CT_SEL_LO = 1;
	localparam int CT_START = 0;
	localparam logic [WORD_W-1:0] STATUS_RESET = 16'h0000;
	localparam logic [DATA_W-1:0] CAL_RESET = 14'h0000;

	typedef struct packed {
		logic [1:0] power_mgmt;
		logic [1:0] read_select;
		logic mode1;
		logic cal_kind_sel;
		logic [1:0] cal_select;
		logic start_calibration;
	} ctrl_t;
endpackage
`default_nettype wire

// [verilog/cal_pointer.sv]
`timescale 1ns/1ps
`default_nettype none
module cal_pointer (
	input wire logic clk,
	input wire logic resetn,
	input wire logic load,
	input wire logic [1:0] sel,
	input wire logic step,
	output logic [3:0] ptr
);
	logic [3:0] ptr_r;
	logic [3:0] ptr_nxt;

	function automatic logic [3:0] first_of(input logic [1:0] s);
		first_of = (s == cal_regs_pkg::SEL_OFF) ? cal_regs_pkg::PTR_OFFSET
			: cal_regs_pkg::PTR_GAIN;
	endfunction

	function automatic logic [3:0] last_of(input logic [1:0] s);
		case (s)
			cal_regs_pkg::SEL_ALL: last_of = cal_regs_pkg::PTR_LAST;
			cal_regs_pkg::SEL_GAIN_OFF: last_of = cal_regs_pkg::PTR_OFFSET;
			cal_regs_pkg::SEL_OFF: last_of = cal_regs_pkg::PTR_OFFSET;
			default: last_of = cal_regs_pkg::PTR_GAIN;
		endcase
	endfunction

	always_comb begin
		ptr_nxt = ptr_r;
		if (load) begin
			ptr_nxt = first_of(sel);
		end else if (step) begin
			if (ptr_r == last_of(sel)) begin
				ptr_nxt = first_of(sel);
			end else begin
				ptr_nxt = ptr_r + 4'h1;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ptr_r <= cal_regs_pkg::PTR_GAIN;
		end else begin
			ptr_r <= ptr_nxt;
		end
	end

	assign ptr = ptr_r;
endmodule // cal_pointer
`default_nettype wire

// [verilog/sync2.sv]
`timescale 1ns/1ps
`default_nettype none
module sync2 (
	input wire logic clk,
	input wire logic resetn,
	input wire logic d,
	output logic q
);
	logic meta_r;
	logic q_r;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= 1'b0;
			q_r <= 1'b0;
		end else begin
			meta_r <= d;
			q_r <= meta_r;
		end
	end
	assign q = q_r;
endmodule // sync2
`default_nettype wire

// [verilog/adc_status_and_cal_access.sv]
// Function
// - status word is 16 bits, read only; never written directly, built from control fields and busy flags
// - status reads all zero after power-up
// - bits 15 and 13..10 always read zero
// - bit 14 is one while conversion or calibration runs
// - bits 9..8 mirror the power management setting
// - bits 7 and 6 read one, except in the all-zero power-up status
// - bit 5 shows interface mode; cleared after every read cycle without a control write in the same cycle
// - bit 3 shows calibration kind: zero self, one system
// - bit 0 shows calibration running; bits 2..1 show selected group
// - ten calibration registers, eight dac, offset, gain, all host accessible
// - calibration engine updates the registers without host access
// - select field 00 all ten, 01 gain+offset, 10 offset, 11 gain
// - pointer resets on control write with start cleared and at end of group
// - reset pointer addresses gain, except offset-only selects offset
// - pointer advances by one after each register access
// - host may abort; next control write with start cleared resets pointer
// - calibration read data starts with two zero bits
// - control write with start cleared decodes select as address
// - offset and gain words are two zeros plus 14 data bits
`timescale 1ns/1ps
`default_nettype none
module adc_status_and_cal_access #(
	parameter int NUM_CAL = cal_regs_pkg::NUM_CAL
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic ctrl_wr,
	input wire logic [15:0] ctrl_wdata,
	input wire logic cal_wr,
	input wire logic [15:0] cal_wdata,
	input wire logic rd_xfer,
	input wire logic conv_busy,
	input wire logic cal_done,
	input wire logic eng_wr,
	input wire logic [3:0] eng_addr,
	input wire logic [13:0] eng_data,
	input wire logic sleep_n_pin,
	output logic [15:0] rd_data,
	output logic sleep_active,
	output logic cal_running,
	output logic mode1,
	output logic [3:0] cal_ptr
);
	cal_regs_pkg::ctrl_t ctrl_r;
	logic cal_run_r;
	logic [15:0] rd_data_r;
	logic [cal_regs_pkg::DATA_W-1:0] cal_mem_r [NUM_CAL];
	logic [15:0] status_w;
	logic ptr_load;
	logic ptr_step;
	logic sleep_sync;
	logic cal_rd;
	logic start_cal;

	sync2 u_sleep (
		.clk(clk),
		.resetn(resetn),
		.d(~sleep_n_pin),
		.q(sleep_sync)
	);

	// a start write kicks the engine; select is then a kind, not an address
	assign start_cal = ctrl_wr && ctrl_wdata[cal_regs_pkg::CT_START];
	assign ptr_load = ctrl_wr && !ctrl_wdata[cal_regs_pkg::CT_START];
	assign cal_rd = rd_xfer && (ctrl_r.read_select == cal_regs_pkg::RD_CAL);
	assign ptr_step = !ptr_load && (cal_wr || cal_rd);

	cal_pointer u_ptr (
		.clk(clk),
		.resetn(resetn),
		.load(ptr_load),
		.sel(ptr_load ? ctrl_wdata[cal_regs_pkg::CT_SEL_LO +: 2] : ctrl_r.cal_select),
		.step(ptr_step),
		.ptr(cal_ptr)
	);

	// control fields reflected in status
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= '0;
		end else if (ctrl_wr) begin
			ctrl_r.power_mgmt <= ctrl_wdata[cal_regs_pkg::CT_PM_LO +: 2];
			ctrl_r.read_select <= ctrl_wdata[cal_regs_pkg::CT_RD_LO +: 2];
			ctrl_r.mode1 <= ctrl_wdata[cal_regs_pkg::CT_MODE];
			ctrl_r.cal_kind_sel <= ctrl_wdata[cal_regs_pkg::CT_KIND];
			ctrl_r.cal_select <= ctrl_wdata[cal_regs_pkg::CT_SEL_LO +: 2];
			ctrl_r.start_calibration <= ctrl_wdata[cal_regs_pkg::CT_START];
		end else if (rd_xfer) begin
			ctrl_r.mode1 <= 1'b0;
		end
	end

	// calibration run flag; set wins over done
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cal_run_r <= 1'b0;
		end else if (start_cal) begin
			cal_run_r <= 1'b1;
		end else if (cal_done) begin
			cal_run_r <= 1'b0;
		end
	end

	// coefficient store; engine has priority since host must not write mid-cal
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			for (int i = 0; i < NUM_CAL; i++) begin
				cal_mem_r[i] <= cal_regs_pkg::CAL_RESET;
			end
		end else if (eng_wr && (eng_addr < 4'(NUM_CAL))) begin
			cal_mem_r[eng_addr] <= eng_data;
		end else if (cal_wr && !ptr_load && (cal_ptr < 4'(NUM_CAL))) begin
			cal_mem_r[cal_ptr] <= cal_wdata[cal_regs_pkg::DATA_W-1:0];
		end
	end

	always_comb begin
		status_w = cal_regs_pkg::STATUS_RESET;
		status_w[cal_regs_pkg::ST_BUSY] = conv_busy || cal_run_r;
		status_w[cal_regs_pkg::ST_PM_HI] = ctrl_r.power_mgmt[1];
		status_w[cal_regs_pkg::ST_PM_LO] = ctrl_r.power_mgmt[0];
		status_w[cal_regs_pkg::ST_RD_HI] = 1'b1;
		status_w[cal_regs_pkg::ST_RD_LO] = 1'b1;
		status_w[cal_regs_pkg::ST_MODE] = ctrl_r.mode1;
		status_w[cal_regs_pkg::ST_KIND] = ctrl_r.cal_kind_sel;
		status_w[cal_regs_pkg::ST_SEL_HI] = ctrl_r.cal_select[1];
		status_w[cal_regs_pkg::ST_SEL_LO] = ctrl_r.cal_select[0];
		status_w[cal_regs_pkg::ST_CAL] = cal_run_r;
		// status shows zero while all control fields are zero and nothing is busy (power-up value)
		if (!ctrl_r.read_select[1] && !cal_run_r && !conv_busy && ctrl_r == '0) begin
			status_w = cal_regs_pkg::STATUS_RESET;
		end
	end

	// read word registered for the serial shifter; refreshed every cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data_r <= cal_regs_pkg::STATUS_RESET;
		end else if (ctrl_r.read_select == cal_regs_pkg::RD_STATUS) begin
			rd_data_r <= status_w;
		end else if (ctrl_r.read_select == cal_regs_pkg::RD_CAL && cal_ptr < 4'(NUM_CAL)) begin
			rd_data_r <= {2'b00, cal_mem_r[cal_ptr]};
		end else begin
			rd_data_r <= cal_regs_pkg::STATUS_RESET;
		end
	end

	assign rd_data = rd_data_r;
	assign sleep_active = sleep_sync && (ctrl_r.power_mgmt == 2'h0);
	assign cal_running = cal_run_r;
	assign mode1 = ctrl_r.mode1;

	a_busy_bit: assert property (@(posedge clk) disable iff (!resetn)
		status_w[cal_regs_pkg::ST_BUSY] == (conv_busy || cal_run_r))
		else $error("busy bit wrong");
	a_fixed_zero: assert property (@(posedge clk) disable iff (!resetn)
		status_w[15] == 1'b0 && status_w[13:10] == 4'h0)
		else $error("reserved status bits not zero");
	a_mode_clear: assert property (@(posedge clk) disable iff (!resetn)
		rd_xfer && !ctrl_wr |=> !mode1)
		else $error("mode bit not cleared after read");
	a_ptr_load: assert property (@(posedge clk) disable iff (!resetn)
		ptr_load && ctrl_wdata[2:1] == cal_regs_pkg::SEL_OFF |=> cal_ptr == cal_regs_pkg::PTR_OFFSET)
		else $error("offset-only pointer wrong");
	a_ptr_gain: assert property (@(posedge clk) disable iff (!resetn)
		ptr_load && ctrl_wdata[2:1] != cal_regs_pkg::SEL_OFF |=> cal_ptr == cal_regs_pkg::PTR_GAIN)
		else $error("pointer not reset to gain");
	a_ptr_step: assert property (@(posedge clk) disable iff (!resetn)
		ptr_step && ctrl_r.cal_select == cal_regs_pkg::SEL_ALL && cal_ptr != 4'h9
		|=> cal_ptr == $past(cal_ptr) + 4'h1)
		else $error("pointer did not advance");
	a_ptr_wrap: assert property (@(posedge clk) disable iff (!resetn)
		ptr_step && cal_ptr == 4'h9 |=> cal_ptr == cal_regs_pkg::PTR_GAIN)
		else $error("pointer did not wrap");
	a_lead_zeros: assert property (@(posedge clk) disable iff (!resetn)
		ctrl_r.read_select == cal_regs_pkg::RD_CAL |=> rd_data[15:14] == 2'b00)
		else $error("leading zeros missing");
	a_id_bits: assert property (@(posedge clk) disable iff (!resetn)
		ctrl_r.read_select == cal_regs_pkg::RD_STATUS && !ctrl_wr |=> rd_data[7:6] == 2'b11)
		else $error("status id bits wrong");
	a_cal_flag: assert property (@(posedge clk) disable iff (!resetn)
		start_cal |=> cal_running && status_w[0])
		else $error("calibration flag not set");
	c_full_walk: cover property (@(posedge clk) disable iff (!resetn)
		ptr_step && cal_ptr == 4'h9);
	c_status_read: cover property (@(posedge clk) disable iff (!resetn)
		rd_xfer && ctrl_r.read_select == cal_regs_pkg::RD_STATUS);
	c_abort: cover property (@(posedge clk) disable iff (!resetn)
		ptr_load && cal_ptr != cal_regs_pkg::PTR_GAIN);
endmodule // adc_status_and_cal_access
`default_nettype wire

// [sim/host_model.sv]
`timescale 1ns/1ps
`default_nettype none
module host_model (
	input wire logic clk,
	output logic ctrl_wr,
	output logic [15:0] ctrl_wdata,
	output logic cal_wr,
	output logic [15:0] cal_wdata,
	output logic rd_xfer
);
	initial begin
		ctrl_wr = 1'b0;
		cal_wr = 1'b0;
		rd_xfer = 1'b0;
		ctrl_wdata = 16'h0000;
		cal_wdata = 16'h0000;
	end
	// control word always precedes an access sequence
	task automatic send_ctrl(input logic [15:0] w);
		@(negedge clk);
		ctrl_wdata = w;
		ctrl_wr = 1'b1;
		@(negedge clk);
		ctrl_wr = 1'b0;
		ctrl_wdata = ~w; // released bus never shows a stale word
	endtask
	// one whole transfer per pointer step, never mixed with reads
	task automatic send_cal(input logic [15:0] w);
		@(negedge clk);
		cal_wdata = w;
		cal_wr = 1'b1;
		@(negedge clk);
		cal_wr = 1'b0;
		cal_wdata = ~w;
	endtask
	task automatic send_rd();
		@(negedge clk);
		rd_xfer = 1'b1;
		@(negedge clk);
		rd_xfer = 1'b0;
	endtask
endmodule // host_model
`default_nettype wire

// [sim/adc_status_and_cal_access_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module adc_status_and_cal_access_tb_top;
	logic clk, resetn, ctrl_wr, cal_wr, rd_xfer, conv_busy, cal_done, eng_wr, sleep_n_pin;
	logic sleep_active, cal_running, mode1, busy;
	logic [15:0] ctrl_wdata, cal_wdata, rd_data, c;
	logic [13:0] eng_data, d;
	logic [13:0] cal [10];
	logic [3:0] eng_addr, cal_ptr, p;
	int miscompares = 0;
	int tests_run = 0;
	int seed = 75619;
	host_model host_model_inst (.clk(clk), .ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata),
		.cal_wr(cal_wr), .cal_wdata(cal_wdata), .rd_xfer(rd_xfer));
	adc_status_and_cal_access adc_status_and_cal_access_inst (.clk(clk), .resetn(resetn),
		.ctrl_wr(ctrl_wr), .ctrl_wdata(ctrl_wdata), .cal_wr(cal_wr), .cal_wdata(cal_wdata),
		.rd_xfer(rd_xfer), .conv_busy(conv_busy), .cal_done(cal_done), .eng_wr(eng_wr),
		.eng_addr(eng_addr), .eng_data(eng_data), .sleep_n_pin(sleep_n_pin),
		.rd_data(rd_data), .sleep_active(sleep_active), .cal_running(cal_running),
		.mode1(mode1), .cal_ptr(cal_ptr));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic w(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [15:0] st_exp(input logic [15:0] cw, input logic bz, input logic cr);
		st_exp = 16'h00c0;
		st_exp[14] = bz | cr;
		st_exp[9:8] = cw[9:8];
		st_exp[5] = cw[5];
		st_exp[3] = cw[3];
		st_exp[2:1] = cw[2:1];
		st_exp[0] = cr;
	endfunction
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial begin
		resetn = 1'b0;
		conv_busy = 1'b0;
		cal_done = 1'b0;
		eng_wr = 1'b0;
		eng_addr = 4'h0;
		eng_data = 14'h0000;
		sleep_n_pin = 1'b1;
		repeat (3) @(negedge clk);
		resetn = 1'b1;
		w(1);
		chk("rd_data", 16'h0000, rd_data);
		chk("cal_ptr", 16'h0000, {12'h000, cal_ptr});
		chk("mode1", 16'h0000, {15'h0000, mode1});
		$display("test reset done");
		for (int i = 0; i < 6; i++) begin
			c = 16'($random(seed)) & 16'h032e | 16'h00c0;
			c[5] = c[5] | (i == 0);
			busy = 1'($random(seed));
			conv_busy = busy;
			host_model_inst.send_ctrl(c);
			host_model_inst.send_cal(16'h3fff);
			w(2);
			chk("status", st_exp(c, busy, 1'b0), rd_data & 16'hffef);
			chk("mode1", {15'h0000, c[5]}, {15'h0000, mode1});
			host_model_inst.send_rd();
			w(2);
			chk("status_rd", st_exp(c & 16'hffdf, busy, 1'b0), rd_data & 16'hffef);
		end
		conv_busy = 1'b0;
		$display("test status done");
		host_model_inst.send_ctrl(16'h0000);
		for (int i = 0; i < 10; i++) begin
			c = 16'($random(seed));
			cal[i] = c[13:0];
			host_model_inst.send_cal(c);
		end
		w(2);
		chk("ptr_wrap", 16'h0000, {12'h000, cal_ptr});
		for (int s = 0; s < 4; s++) begin
			host_model_inst.send_ctrl(16'h0080 | 16'(s << 1));
			w(2);
			for (int k = 0; k < (s == 0 ? 10 : s == 1 ? 2 : 1); k++) begin
				p = 4'((s == 2 ? 1 : 0) + k);
				chk("cal_ptr", {12'h000, p}, {12'h000, cal_ptr});
				chk("cal_data", {2'b00, cal[p]}, rd_data);
				host_model_inst.send_rd();
				w(2);
			end
			chk("ptr_end", {12'h000, 4'(s == 2 ? 1 : 0)}, {12'h000, cal_ptr});
		end
		// abandon a walk part way
		host_model_inst.send_ctrl(16'h0080);
		host_model_inst.send_rd();
		host_model_inst.send_rd();
		w(1);
		chk("ptr_mid", 16'h0002, {12'h000, cal_ptr});
		host_model_inst.send_ctrl(16'h0082);
		w(2);
		chk("abort_ptr", 16'h0000, {12'h000, cal_ptr});
		$display("test cal access done");
		host_model_inst.send_ctrl(16'h00c9);
		w(2);
		chk("status_cal", st_exp(16'h00c9, 1'b0, 1'b1), rd_data & 16'hffef);
		d = 14'($random(seed));
		eng_addr = 4'($random(seed) & 1);
		eng_data = d;
		eng_wr = 1'b1;
		w(1);
		eng_wr = 1'b0;
		eng_data = ~d;
		cal_done = 1'b1;
		w(1);
		cal_done = 1'b0;
		w(2);
		chk("cal_running", 16'h0000, {15'h0000, cal_running});
		host_model_inst.send_ctrl(eng_addr[0] ? 16'h0084 : 16'h0086);
		w(2);
		chk("eng_data", {2'b00, d}, rd_data);
		$display("test calibration done");
		host_model_inst.send_ctrl(16'h0000);
		sleep_n_pin = 1'($random(seed));
		w(4);
		chk("sleep", {15'h0000, ~sleep_n_pin}, {15'h0000, sleep_active});
		sleep_n_pin = ~sleep_n_pin;
		w(4);
		chk("wake", {15'h0000, ~sleep_n_pin}, {15'h0000, sleep_active});
		$display("test power done");
		give_verdict();
	end
	// run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		miscompares++;
		give_verdict();
	end
endmodule // adc_status_and_cal_access_tb_top
`default_nettype wire
